// File: dbt_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module dbt_event_src (
  // clock
  input wire logic pclk,
  // which pin carries events
  input wire logic [1:0] run,
  // event pins
  output logic ext_irq_pin_a,
  output logic ext_irq_pin_b
);
  logic [2:0] ph_ff = 3'h0;
  logic a_ff = 1'b0;
  logic b_ff = 1'b0;
  // one rising edge every 8 cycles, pins stay low when idle
  always_ff @(posedge pclk) begin
    ph_ff <= (|run) ? ph_ff + 3'h1 : 3'h0;
    a_ff <= run[0] && ph_ff[2];
    b_ff <= run[1] && ph_ff[2];
  end
  assign ext_irq_pin_a = a_ff;
  assign ext_irq_pin_b = b_ff;
endmodule // dbt_event_src
`default_nettype wire

// File: dbt_pkg.sv
package dbt_pkg;
  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_TIMER_CONTROL = 16'hFE18;
  localparam logic [15:0] IDX_PRESCALER_CONTROL = 16'hFE19;
  localparam logic [15:0] IDX_LOW_COUNT = 16'hFE1A;
  localparam logic [15:0] IDX_HIGH_COUNT = 16'hFE1B;
  localparam logic [15:0] IDX_LOW_MATCH = 16'hFE1C;
  localparam logic [15:0] IDX_HIGH_MATCH = 16'hFE1D;
  localparam logic [15:0] IDX_EXT_PIN_SELECT = 16'hFE1E;
  localparam int ADDR_W = 18;
  // timer_control bits
  localparam int B_HIGH_RUN = 7;
  localparam int B_LOW_RUN = 6;
  localparam int B_CASCADE = 5;
  localparam int B_PWM = 4;
  localparam int B_HIGH_FLAG = 3;
  localparam int B_HIGH_IE = 2;
  localparam int B_LOW_FLAG = 1;
  localparam int B_LOW_IE = 0;
  // prescaler_control bits
  localparam int B_HIGH_PRE_EN = 7;
  localparam int B_HIGH_PRE_SEL_HI = 6;
  localparam int B_HIGH_PRE_SEL_LO = 4;
  localparam int B_LOW_PRE_EN = 3;
  localparam int B_LOW_PRE_SEL_HI = 2;
  localparam int B_LOW_PRE_SEL_LO = 0;
  // ext_pin_select_reg bits
  localparam int B_SEL_PIN_A = 0;
  localparam int B_SEL_PIN_B = 1;
  localparam logic [1:0] EXT_SEL_MASK = 2'h3;
  // reset values and constants
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [8:0] PRE_BASE = 9'h002;
endpackage

// File: dbt_timer.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dbt_timer (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event pins
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  // outputs
  output logic low_output_pin,
  output logic high_output_pin,
  output logic low_irq,
  output logic high_irq
);

  // prescaler terminal count: true when count reaches the selected division minus one
  function automatic logic pre_hit(input logic [7:0] cnt, input logic en,
                                   input logic [2:0] sel);
    logic [8:0] lim;
    lim = dbt_pkg::PRE_BASE << sel;
    pre_hit = en ? (cnt == 8'(lim - 9'h001)) : 1'b1;
  endfunction

  // register address decode
  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    hit = (a == {14'h0000, idx, 2'h0});
  endfunction

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] pre_ctrl_ff, nxt_pre_ctrl;
  logic [7:0] low_match_ff, nxt_low_match;
  logic [7:0] high_match_ff, nxt_high_match;
  logic [1:0] ext_sel_ff, nxt_ext_sel;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  logic half_ff, nxt_half;
  logic pin_prev_ff, nxt_pin_prev;
  logic [7:0] low_pre_ff, nxt_low_pre;
  logic [7:0] high_pre_ff, nxt_high_pre;
  logic [7:0] low_cnt_ff, nxt_low_cnt;
  logic [7:0] high_cnt_ff, nxt_high_cnt;
  logic [7:0] low_buf_ff, nxt_low_buf;
  logic [7:0] high_buf_ff, nxt_high_buf;
  logic low_out_ff, nxt_low_out;
  logic high_out_ff, nxt_high_out;
  logic low_irq_ff, nxt_low_irq;
  logic high_irq_ff, nxt_high_irq;

  logic low_run, high_run, cascade, pwm, high_pwm;
  logic ev_pin, ev_edge, low_in, high_in;
  logic low_tick, high_tick, low_match_ev, high_match_ev;
  logic low_period, high_period, low_ovf, high_ovf;
  logic access, wr;
  logic mapped;

  assign low_run = ctrl_ff[dbt_pkg::B_LOW_RUN];
  assign high_run = ctrl_ff[dbt_pkg::B_HIGH_RUN];
  assign cascade = ctrl_ff[dbt_pkg::B_CASCADE];
  assign pwm = ctrl_ff[dbt_pkg::B_PWM];
  assign high_pwm = pwm & ~cascade;

  // event input; either selected pin counts, rising edges only
  assign ev_pin = (ext_sel_ff[dbt_pkg::B_SEL_PIN_A] & ext_irq_pin_a) |
                  (ext_sel_ff[dbt_pkg::B_SEL_PIN_B] & ext_irq_pin_b);
  assign ev_edge = ev_pin & ~pin_prev_ff;

  // low prescaler input; event pin in pwm mode would upset the low byte
  always_comb begin
    if (pwm) begin
      low_in = 1'b1;
    end else if (|ext_sel_ff) begin
      low_in = ev_edge;
    end else begin
      low_in = half_ff;
    end
  end

  assign low_tick = low_run & low_in &
                    pre_hit(low_pre_ff, pre_ctrl_ff[dbt_pkg::B_LOW_PRE_EN],
                            pre_ctrl_ff[dbt_pkg::B_LOW_PRE_SEL_HI:dbt_pkg::B_LOW_PRE_SEL_LO]);
  assign low_match_ev = low_tick & (low_cnt_ff == low_buf_ff);
  assign low_ovf = low_tick & (low_cnt_ff == dbt_pkg::BYTE_ALL_ONES);
  // in pwm mode the low period ends at overflow, otherwise at match
  assign low_period = pwm ? low_ovf : low_match_ev;

  // high prescaler input per mode
  always_comb begin
    unique case ({cascade, pwm})
      2'h0: high_in = half_ff;
      2'h1: high_in = 1'b1;
      2'h2: high_in = low_match_ev;
      default: high_in = low_ovf;
    endcase
  end

  assign high_tick = high_run & high_in &
                     pre_hit(high_pre_ff, pre_ctrl_ff[dbt_pkg::B_HIGH_PRE_EN],
                             pre_ctrl_ff[dbt_pkg::B_HIGH_PRE_SEL_HI:dbt_pkg::B_HIGH_PRE_SEL_LO]);
  assign high_match_ev = high_tick & (high_cnt_ff == high_buf_ff);
  assign high_ovf = high_tick & (high_cnt_ff == dbt_pkg::BYTE_ALL_ONES);
  assign high_period = high_pwm ? high_ovf : high_match_ev;

  // bus access decode
  assign access = psel & penable & ~pready_ff;
  assign wr = access & pwrite;
  assign mapped = hit(paddr, dbt_pkg::IDX_TIMER_CONTROL) |
                  hit(paddr, dbt_pkg::IDX_PRESCALER_CONTROL) |
                  hit(paddr, dbt_pkg::IDX_LOW_COUNT) |
                  hit(paddr, dbt_pkg::IDX_HIGH_COUNT) |
                  hit(paddr, dbt_pkg::IDX_LOW_MATCH) |
                  hit(paddr, dbt_pkg::IDX_HIGH_MATCH) |
                  hit(paddr, dbt_pkg::IDX_EXT_PIN_SELECT);

  // register file and bus answer
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_pre_ctrl = pre_ctrl_ff;
    nxt_low_match = low_match_ff;
    nxt_high_match = high_match_ff;
    nxt_ext_sel = ext_sel_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = access;
    nxt_pslverr = access & ~mapped;
    if (wr && hit(paddr, dbt_pkg::IDX_TIMER_CONTROL)) begin
      nxt_ctrl = pwdata[7:0];
    end
    if (wr && hit(paddr, dbt_pkg::IDX_PRESCALER_CONTROL)) begin
      nxt_pre_ctrl = pwdata[7:0];
    end
    if (wr && hit(paddr, dbt_pkg::IDX_LOW_MATCH)) begin
      nxt_low_match = pwdata[7:0];
    end
    if (wr && hit(paddr, dbt_pkg::IDX_HIGH_MATCH)) begin
      nxt_high_match = pwdata[7:0];
    end
    if (wr && hit(paddr, dbt_pkg::IDX_EXT_PIN_SELECT)) begin
      nxt_ext_sel = pwdata[1:0] & dbt_pkg::EXT_SEL_MASK;
    end
    // hardware set wins over a software clear in the same cycle
    if (low_period) begin
      nxt_ctrl[dbt_pkg::B_LOW_FLAG] = 1'b1;
    end
    if (high_period) begin
      nxt_ctrl[dbt_pkg::B_HIGH_FLAG] = 1'b1;
    end
    if (access && !pwrite) begin
      nxt_prdata = 32'h00000000;
      if (hit(paddr, dbt_pkg::IDX_TIMER_CONTROL)) begin
        nxt_prdata[7:0] = ctrl_ff;
      end
      if (hit(paddr, dbt_pkg::IDX_PRESCALER_CONTROL)) begin
        nxt_prdata[7:0] = pre_ctrl_ff;
      end
      if (hit(paddr, dbt_pkg::IDX_LOW_COUNT)) begin
        nxt_prdata[7:0] = low_cnt_ff;
      end
      if (hit(paddr, dbt_pkg::IDX_HIGH_COUNT)) begin
        nxt_prdata[7:0] = high_cnt_ff;
      end
      if (hit(paddr, dbt_pkg::IDX_LOW_MATCH)) begin
        nxt_prdata[7:0] = low_match_ff;
      end
      if (hit(paddr, dbt_pkg::IDX_HIGH_MATCH)) begin
        nxt_prdata[7:0] = high_match_ff;
      end
      if (hit(paddr, dbt_pkg::IDX_EXT_PIN_SELECT)) begin
        nxt_prdata[1:0] = ext_sel_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= dbt_pkg::RST_BYTE;
      pre_ctrl_ff <= dbt_pkg::RST_BYTE;
      low_match_ff <= dbt_pkg::RST_BYTE;
      high_match_ff <= dbt_pkg::RST_BYTE;
      ext_sel_ff <= 2'h0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      pre_ctrl_ff <= nxt_pre_ctrl;
      low_match_ff <= nxt_low_match;
      high_match_ff <= nxt_high_match;
      ext_sel_ff <= nxt_ext_sel;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // timer datapath
  always_comb begin
    nxt_half = ~half_ff;
    nxt_pin_prev = ev_pin;
    nxt_low_pre = low_pre_ff;
    nxt_high_pre = high_pre_ff;
    nxt_low_cnt = low_cnt_ff;
    nxt_high_cnt = high_cnt_ff;
    nxt_low_buf = low_buf_ff;
    nxt_high_buf = high_buf_ff;
    nxt_low_out = low_out_ff;
    nxt_high_out = high_out_ff;

    // low prescaler and counter
    if (!low_run) begin
      nxt_low_pre = dbt_pkg::RST_BYTE;
      nxt_low_cnt = dbt_pkg::RST_BYTE;
      nxt_low_buf = low_match_ff;
    end else if (low_in) begin
      if (low_tick) begin
        nxt_low_pre = dbt_pkg::RST_BYTE;
        if (low_match_ev && !pwm) begin
          nxt_low_cnt = dbt_pkg::RST_BYTE;
        end else begin
          nxt_low_cnt = low_cnt_ff + dbt_pkg::BYTE_ONE;
        end
      end else begin
        nxt_low_pre = low_pre_ff + dbt_pkg::BYTE_ONE;
      end
    end
    if (low_run && low_period) begin
      nxt_low_buf = low_match_ff;
    end

    // high prescaler and counter; mode 1 wraps instead of clearing
    if (!high_run) begin
      nxt_high_pre = dbt_pkg::RST_BYTE;
      nxt_high_cnt = dbt_pkg::RST_BYTE;
      nxt_high_buf = high_match_ff;
    end else if (high_in) begin
      if (high_tick) begin
        nxt_high_pre = dbt_pkg::RST_BYTE;
        if (high_match_ev && !high_pwm) begin
          nxt_high_cnt = dbt_pkg::RST_BYTE;
        end else begin
          nxt_high_cnt = high_cnt_ff + dbt_pkg::BYTE_ONE;
        end
      end else begin
        nxt_high_pre = high_pre_ff + dbt_pkg::BYTE_ONE;
      end
    end
    if (high_run && high_period) begin
      nxt_high_buf = high_match_ff;
    end

    // low output
    if (!low_run) begin
      nxt_low_out = 1'b1;
    end else if (low_match_ff == dbt_pkg::BYTE_ALL_ONES) begin
      nxt_low_out = 1'b0;
    end else if (pwm) begin
      if (low_ovf) begin
        nxt_low_out = 1'b0;
      end else if (low_match_ev) begin
        nxt_low_out = 1'b1;
      end
    end else if (low_match_ev) begin
      nxt_low_out = ~low_out_ff;
    end

    // high output; toggles in cascade modes
    if (!high_run) begin
      nxt_high_out = 1'b1;
    end else if (high_match_ff == dbt_pkg::BYTE_ALL_ONES) begin
      nxt_high_out = 1'b0;
    end else if (high_pwm) begin
      if (high_ovf) begin
        nxt_high_out = 1'b0;
      end else if (high_match_ev) begin
        nxt_high_out = 1'b1;
      end
    end else if (high_match_ev) begin
      nxt_high_out = ~high_out_ff;
    end

    nxt_low_irq = nxt_ctrl[dbt_pkg::B_LOW_FLAG] & nxt_ctrl[dbt_pkg::B_LOW_IE];
    nxt_high_irq = nxt_ctrl[dbt_pkg::B_HIGH_FLAG] & nxt_ctrl[dbt_pkg::B_HIGH_IE];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
      low_pre_ff <= dbt_pkg::RST_BYTE;
      high_pre_ff <= dbt_pkg::RST_BYTE;
      low_cnt_ff <= dbt_pkg::RST_BYTE;
      high_cnt_ff <= dbt_pkg::RST_BYTE;
      low_buf_ff <= dbt_pkg::RST_BYTE;
      high_buf_ff <= dbt_pkg::RST_BYTE;
      low_out_ff <= 1'b1;
      high_out_ff <= 1'b1;
      low_irq_ff <= 1'b0;
      high_irq_ff <= 1'b0;
    end else if (ce) begin
      half_ff <= nxt_half;
      pin_prev_ff <= nxt_pin_prev;
      low_pre_ff <= nxt_low_pre;
      high_pre_ff <= nxt_high_pre;
      low_cnt_ff <= nxt_low_cnt;
      high_cnt_ff <= nxt_high_cnt;
      low_buf_ff <= nxt_low_buf;
      high_buf_ff <= nxt_high_buf;
      low_out_ff <= nxt_low_out;
      high_out_ff <= nxt_high_out;
      low_irq_ff <= nxt_low_irq;
      high_irq_ff <= nxt_high_irq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign low_output_pin = low_out_ff;
  assign high_output_pin = high_out_ff;
  assign low_irq = low_irq_ff;
  assign high_irq = high_irq_ff;

endmodule // dbt_timer
`default_nettype wire

// File: dbt_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dbt_timer_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic low_output_pin,
  input wire logic high_output_pin,
  input wire logic low_irq,
  input wire logic high_irq
);
  logic [7:0] ctl_ff, nxt_ctl, lm_ff, nxt_lm;
  logic wr;
  // shadow takes a write on the same edge as the register, so no slack is needed
  assign wr = psel && penable && !pready && ce && pwrite;
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_lm = lm_ff;
    if (wr && paddr == {14'h0000, dbt_pkg::IDX_TIMER_CONTROL, 2'h0}) begin
      nxt_ctl = pwdata[7:0];
    end
    if (wr && paddr == {14'h0000, dbt_pkg::IDX_LOW_MATCH, 2'h0}) begin
      nxt_lm = pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 8'h00;
      lm_ff <= 8'h00;
    end else begin
      ctl_ff <= nxt_ctl;
      lm_ff <= nxt_lm;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_rdata_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr[17:2] > 16'hFE1E
    || paddr[17:2] < 16'hFE18)) else $error("wrong pslverr");
  a_irq_low_gate: assert property (low_irq |-> ctl_ff[0])
    else $error("low irq while disabled");
  a_irq_high_gate: assert property (high_irq |-> ctl_ff[2])
    else $error("high irq while disabled");
  a_low_stop_high: assert property ((!ctl_ff[6])[*3] |-> low_output_pin)
    else $error("low pin not high when stopped");
  a_high_stop_high: assert property ((!ctl_ff[7])[*3] |-> high_output_pin)
    else $error("high pin not high when stopped");
  a_ff_holds_low: assert property ((ctl_ff[6] && lm_ff == 8'hFF)[*3] |-> !low_output_pin)
    else $error("low pin not low at match FF");
  a_low_cnt_clear: assert property ((!ctl_ff[6])[*4] ##0 (pready && !pwrite
    && paddr[17:2] == dbt_pkg::IDX_LOW_COUNT) |-> prdata[7:0] == 8'h00)
    else $error("low count not cleared");
  c_low_irq: cover property ($rose(low_irq));
  c_high_irq: cover property ($rose(high_irq));
  c_slverr: cover property (pready && pslverr);
endmodule // dbt_timer_chk
bind dbt_timer dbt_timer_chk i_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_irq_pin_a(ext_irq_pin_a),
  .ext_irq_pin_b(ext_irq_pin_b), .low_output_pin(low_output_pin),
  .high_output_pin(high_output_pin), .low_irq(low_irq), .high_irq(high_irq));
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] CT = dbt_pkg::IDX_TIMER_CONTROL;
  localparam logic [15:0] PR = dbt_pkg::IDX_PRESCALER_CONTROL;
  localparam logic [15:0] LM = dbt_pkg::IDX_LOW_MATCH;
  localparam logic [15:0] HM = dbt_pkg::IDX_HIGH_MATCH;
  localparam logic [15:0] ES = dbt_pkg::IDX_EXT_PIN_SELECT;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rerr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic pin_l, pin_h, irq_l, irq_h, ev_a, ev_b;
  logic [1:0] ev_run;
  logic [15:0] regs [7] = '{CT, PR, dbt_pkg::IDX_LOW_COUNT, dbt_pkg::IDX_HIGH_COUNT, LM, HM, ES};
  int n_fail, compares, n, s;
  dbt_timer i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin_a(ev_a), .ext_irq_pin_b(ev_b), .low_output_pin(pin_l),
    .high_output_pin(pin_h), .low_irq(irq_l), .high_irq(irq_h));
  dbt_event_src i_ev (.pclk(pclk), .run(ev_run), .ext_irq_pin_a(ev_a), .ext_irq_pin_b(ev_b));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // idle cycle after each access keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0000, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) n_fail++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic pin(input bit hi);
    return hi ? pin_h : pin_l;
  endfunction
  task automatic wt(input bit hi, input logic lv);
    n = 0;
    while (pin(hi) === lv && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // length of the next whole stretch at level lv
  task automatic meas(input bit hi, input logic lv, input int exp);
    wt(hi, lv);
    wt(hi, ~lv);
    wt(hi, lv);
    chk(n, exp);
  endtask
  task automatic setup(input logic [7:0] pr, input logic [7:0] lm, input logic [7:0] hm,
                       input logic [7:0] ct);
    apb(1'b1, CT, 8'h00);
    apb(1'b1, PR, pr);
    apb(1'b1, LM, lm);
    apb(1'b1, HM, hm);
    apb(1'b1, CT, ct);
  endtask
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    ev_run = 2'h0;
    n_fail = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pin_h, pin_l}, 2'h3);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 8'h00);
      chk(rdat, 32'h00000000);
      apb(1'b1, regs[i], 8'h35);
      apb(1'b0, regs[i], 8'h00);
      chk(rdat, (i == 2 || i == 3) ? 32'h00000000 : (i == 6) ? 32'h00000001 : 32'h00000035);
    end
    apb(1'b1, 16'hFE1F, 8'h00);
    chk(rerr, 1'b1);
    // pin select left set would turn the next tests into event counts
    apb(1'b1, ES, 8'h00);
    for (s = 0; s < 8; s++) begin
      setup({1'b1, s[2:0], 1'b1, s[2:0]}, 8'h03, 8'h01, 8'hC1);
      meas(1'b0, 1'b1, 4 * (2 << s) * 2);
      meas(1'b1, 1'b1, 2 * (2 << s) * 2);
    end
    chk({irq_h, irq_l}, 2'h1);
    apb(1'b1, CT, 8'hC4);
    meas(1'b1, 1'b1, 1024);
    chk({irq_h, irq_l}, 2'h2);
    for (s = 0; s < 2; s++) begin
      setup(8'h00, 8'h01, 8'h00, 8'h00);
      apb(1'b1, ES, 8'h01 << s);
      ev_run <= 2'h1 << s;
      apb(1'b1, CT, 8'h40);
      meas(1'b0, 1'b1, 16);
      ev_run <= 2'h0;
      apb(1'b1, ES, 8'h00);
    end
    setup(8'h00, 8'h3F, 8'h7F, 8'hD0);
    meas(1'b0, 1'b0, 64);
    meas(1'b0, 1'b1, 192);
    meas(1'b1, 1'b0, 128);
    apb(1'b1, LM, 8'hFF);
    repeat (10) @(posedge pclk);
    chk(pin_l, 1'b0);
    apb(1'b1, CT, 8'h00);
    repeat (3) @(posedge pclk);
    chk({pin_h, pin_l}, 2'h3);
    apb(1'b0, dbt_pkg::IDX_LOW_COUNT, 8'h00);
    chk(rdat, 32'h00000000);
    apb(1'b0, dbt_pkg::IDX_HIGH_COUNT, 8'h00);
    chk(rdat, 32'h00000000);
    setup(8'h00, 8'h01, 8'h02, 8'hE1);
    meas(1'b0, 1'b1, 4);
    meas(1'b1, 1'b1, 12);
    chk(irq_l, 1'b1);
    // low pin toggles every 4 cycles here, so a 4-cycle freeze must show no change
    ce <= 1'b0;
    @(posedge pclk);
    rdat = {30'h0, pin_h, pin_l};
    repeat (4) @(posedge pclk);
    chk({pin_h, pin_l}, rdat[1:0]);
    ce <= 1'b1;
    setup(8'h80, 8'h1F, 8'h00, 8'hF0);
    meas(1'b0, 1'b0, 32);
    meas(1'b1, 1'b1, 512);
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
